// ==== rtl/dram_timing_pkg.sv ====
// Purpose: Shared constants for the DRAM timing control block.
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register.
// Notes:
// Contract
// - Register clears only on power-on reset
// - Bit 31 selects row-strobe-hold mode
// - Bit 30: precharge-all or mode-register set
// - Refresh-end precharge equals three times code
// - Bit 23: column negate one or two
// - DRAM precharge cycles equal code
// - SDRAM precharge cycles equal code plus one
// - Row-to-column delay per memory type
// - Auto-precharge write: wait precharge plus delay
// - Hold mode write: delay next precharge
// - Write precharge delay codes 0-4 only
// - Bit 2 enables refresh cycles
package dram_timing_pkg;

  // Register byte address inside the slave window.
  localparam logic [3:0]  TIMING_CTRL_ADDR = 4'h0;
  // Read-only status register holding the decoded cycle counts.
  localparam logic [3:0]  TIMING_STAT_ADDR = 4'h4;
  localparam logic [3:0]  ADDR_WORD_MASK   = 4'hC;

  // Reset value and writable-bit mask of the control register.
  localparam logic [31:0] TIMING_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] TIMING_CTRL_WMASK = 32'hF8BBFFFF;

  // Field positions.
  localparam int HOLD_BIT      = 31;
  localparam int INITCMD_BIT   = 30;
  localparam int RFEND_LSB     = 27;
  localparam int CASNEG_BIT    = 23;
  localparam int PRECH_LSB     = 19;
  localparam int RCD_LSB       = 16;
  localparam int WPD_LSB       = 13;
  localparam int BURST_BIT     = 9;
  localparam int REFRESH_BIT   = 2;

  // Decoding constants.
  localparam logic [4:0]  RFEND_STEP     = 5'h03;
  localparam logic [3:0]  ONE_CYC        = 4'h1;
  localparam logic [3:0]  TWO_CYC        = 4'h2;
  localparam logic [3:0]  RCD_DRAM_BASE  = 4'h2;
  localparam logic [3:0]  RCD_SDRAM_BASE = 4'h1;
  localparam logic [2:0]  WPD_MAX_CODE   = 3'h4;

  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Memory-side sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_ACTIVE, ST_WRITE_REC, ST_PRECHARGE, ST_REFRESH_END} mem_state_e;

endpackage : dram_timing_pkg

// ==== rtl/timing_decode.sv ====
// Purpose: Turns the stored timing codes into cycle counts.
// Assumes: Codes are stable after initialization.
// Notes: Purely combinational; prohibited codes give a clamped count.
`timescale 1ns/1ps
`default_nettype none
module timing_decode
  import dram_timing_pkg::*;
(
  // Stored codes.
  input  wire logic [2:0] rfEndCode,
  input  wire logic       casNegCode,
  input  wire logic [2:0] prechCode,
  input  wire logic [1:0] rcdCode,
  input  wire logic [2:0] wpdCode,
  input  wire logic       isSdram,
  // Decoded counts.
  output logic      [4:0] rfEndCycles,
  output logic      [3:0] casNegCycles,
  output logic      [3:0] prechCycles,
  output logic      [3:0] rcdCycles,
  output logic      [3:0] wpdCycles,
  output logic            wpdIllegal
);

  // Three cycles per code step.
  assign rfEndCycles  = 5'(rfEndCode * RFEND_STEP);
  // Conventional DRAM only; synchronous memory ignores it.
  assign casNegCycles = casNegCode ? TWO_CYC : ONE_CYC;
  // DRAM uses the code directly, SDRAM adds one.
  assign prechCycles  = isSdram ? 4'({1'b0, prechCode} + ONE_CYC)
                                : {1'b0, prechCode};
  // SDRAM code zero is prohibited; it is clamped to the shortest delay.
  assign rcdCycles    = isSdram ? ((rcdCode == 2'h0) ? TWO_CYC
                                   : 4'({2'h0, rcdCode} + RCD_SDRAM_BASE))
                                : 4'({2'h0, rcdCode} + RCD_DRAM_BASE);
  // Prohibited codes are flagged and treated as the largest legal one.
  assign wpdIllegal   = (wpdCode > WPD_MAX_CODE);
  assign wpdCycles    = 4'({1'b0, wpdIllegal ? WPD_MAX_CODE : wpdCode} + ONE_CYC);

endmodule : timing_decode
`default_nettype wire

// ==== rtl/gap_counter.sv ====
// Purpose: Loadable down counter that reports when a gap has elapsed.
// Assumes: A load and the count share one clock.
// Notes: A load of zero means no wait.
`timescale 1ns/1ps
`default_nettype none
module gap_counter (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       load,
  input  wire logic [4:0] loadValue,
  // Status.
  output logic            done
);

  logic [4:0] count_q; // Cycles still to wait.

  // Count down to zero; a fresh load restarts the gap.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 5'h00;
    end else if (load) begin
      count_q <= loadValue;
    end else if (count_q != 5'h00) begin
      count_q <= count_q - 5'h01;
    end
  end

  assign done = (count_q == 5'h00) && !load;

endmodule : gap_counter
`default_nettype wire

// ==== rtl/dram_sdram_timing_control.sv ====
// Purpose: Memory timing control register with command spacing logic.
// Assumes: AXI4-Lite master issues at most one read and one write at a time.
// Notes: rst_n stands for the power-on reset; no other reset touches the register.
`timescale 1ns/1ps
`default_nettype none
module dram_sdram_timing_control
  import dram_timing_pkg::*;
(
  // Clock and power-on reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AXI4-Lite write address.
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // AXI4-Lite write data.
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response.
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // AXI4-Lite read address.
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // AXI4-Lite read data.
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  // Memory type and access events from the bus sequencer.
  input  wire logic        sdramSel,
  input  wire logic        autoPrecharge,
  input  wire logic        activateReq,
  input  wire logic        writeDone,
  input  wire logic        prechargeReq,
  input  wire logic        refreshDone,
  // Timing results toward the memory pins.
  output logic             activateOk,
  output logic             prechargeOk,
  output logic             holdModeOn,
  output logic             initModeRegSet,
  output logic             refreshOn,
  output logic      [3:0]  casNegCycles,
  output logic      [3:0]  rcdCycles
);

  logic [31:0] ctrl_q;      // Stored control word.
  logic        awHeld_q;    // Write address captured.
  logic [3:0]  awAddr_q;    // Captured write address.
  logic        wHeld_q;     // Write data captured.
  logic [31:0] wData_q;     // Captured write data.
  logic [3:0]  wStrb_q;     // Captured byte enables.
  logic        bValid_q;    // Write response pending.
  logic [1:0]  bResp_q;     // Write response code.
  logic        rValid_q;    // Read response pending.
  logic [31:0] rData_q;     // Read data.
  logic [1:0]  rResp_q;     // Read response code.
  logic        wrFire;      // Both halves of a write present.
  logic        rdFire;      // Read address accepted.
  logic [4:0]  rfEndCycles; // Refresh-end precharge count.
  logic [3:0]  prechCycles; // Precharge count.
  logic [3:0]  wpdCycles;   // Write precharge delay count.
  logic        wpdIllegal;  // Prohibited write delay code.
  logic        actLoad;     // Restart of the activate gap.
  logic [4:0]  actGap;      // Length of the activate gap.
  logic        actDone;     // Activate gap has elapsed.
  logic        preDone;     // Precharge gap has elapsed.
  mem_state_e  state_q;     // Sequencer state.
  mem_state_e  state_d;     // Next sequencer state.

  // Byte-lane merge of new data into the present word.
  function automatic logic [31:0] merge_bytes(input logic [31:0] oldWord, input logic [31:0] newWord,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = oldWord;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newWord[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Word address decode shared by the read and write paths.
  function automatic logic is_ctrl(input logic [3:0] addr);
    return (addr & ADDR_WORD_MASK) == TIMING_CTRL_ADDR;
  endfunction : is_ctrl

  function automatic logic is_stat(input logic [3:0] addr);
    return (addr & ADDR_WORD_MASK) == TIMING_STAT_ADDR;
  endfunction : is_stat

  // Channels stay ready until their half is held, so address and data may come in either order.
  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign s_axi_arready = !rValid_q;
  assign wrFire        = awHeld_q && wHeld_q;
  assign rdFire        = s_axi_arvalid && s_axi_arready;

  // Capture write address.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_q <= 1'b0;
    end
  end

  // Capture write data.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_q <= 1'b0;
    end
  end

  // Control register; only the power-on reset clears it, reserved bits never store.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= TIMING_CTRL_RESET;
    end else if (wrFire && is_ctrl(awAddr_q)) begin
      ctrl_q <= merge_bytes(ctrl_q, wData_q, wStrb_q) & TIMING_CTRL_WMASK;
    end
  end

  // Write response; unmapped or read-only addresses answer with an error.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
    end else if (wrFire) begin
      bValid_q <= 1'b1;
      bResp_q  <= is_ctrl(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // Read path; the status word shows decoded counts and the sequencer state.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= RESP_OKAY;
    end else if (rdFire) begin
      rValid_q <= 1'b1;
      if (is_ctrl(s_axi_araddr)) begin
        rData_q <= ctrl_q;
        rResp_q <= RESP_OKAY;
      end else if (is_stat(s_axi_araddr)) begin
        // The packed status fields fill 25 bits; the upper 7 bits read as zero.
        rData_q <= {7'h00, wpdIllegal, 3'(state_q), rfEndCycles, prechCycles, wpdCycles,
                    casNegCycles, rcdCycles};
        rResp_q <= RESP_OKAY;
      end else begin
        rData_q <= 32'h00000000;
        rResp_q <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp  = bResp_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata  = rData_q;
  assign s_axi_rresp  = rResp_q;

  // Mode outputs straight from the stored word.
  assign holdModeOn     = ctrl_q[HOLD_BIT];
  assign initModeRegSet = ctrl_q[INITCMD_BIT];
  assign refreshOn      = ctrl_q[REFRESH_BIT];

  // Code-to-cycle decode.
  timing_decode u_decode (
    .rfEndCode    (ctrl_q[RFEND_LSB +: 3]),
    .casNegCode   (ctrl_q[CASNEG_BIT]),
    .prechCode    (ctrl_q[PRECH_LSB +: 3]),
    .rcdCode      (ctrl_q[RCD_LSB +: 2]),
    .wpdCode      (ctrl_q[WPD_LSB +: 3]),
    .isSdram      (sdramSel),
    .rfEndCycles  (rfEndCycles),
    .casNegCycles (casNegCycles),
    .prechCycles  (prechCycles),
    .rcdCycles    (rcdCycles),
    .wpdCycles    (wpdCycles),
    .wpdIllegal   (wpdIllegal)
  );

  // Sequencer: tracks which gap guards the next command.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (activateReq && actDone) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (writeDone) begin
          state_d = ST_WRITE_REC;
        end else if (prechargeReq && preDone) begin
          state_d = ST_PRECHARGE;
        end
      end
      ST_WRITE_REC: begin
        if (!(sdramSel && holdModeOn) || preDone) begin
          state_d = ST_PRECHARGE;
        end
      end
      ST_PRECHARGE: begin
        state_d = ST_IDLE;
      end
      ST_REFRESH_END: begin
        // Leave as soon as the end precharge has run out, so no extra idle cycle is added.
        if (actDone) begin
          state_d = activateReq ? ST_ACTIVE : ST_IDLE;
        end
      end
    endcase
    // A finished refresh always restarts with its end precharge.
    if (refreshDone) begin
      state_d = ST_REFRESH_END;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Activate gap: precharge, plus write delay after an auto-precharged SDRAM write outside hold mode,
  // or the refresh-end precharge after a refresh.
  always_comb begin
    actLoad = 1'b0;
    actGap  = 5'h00;
    if (refreshDone) begin
      actLoad = 1'b1;
      actGap  = rfEndCycles;
    end else if (writeDone && sdramSel && autoPrecharge && !holdModeOn) begin
      actLoad = 1'b1;
      actGap  = 5'({1'b0, prechCycles} + {1'b0, wpdCycles});
    end else if (state_q == ST_PRECHARGE) begin
      actLoad = 1'b1;
      actGap  = {1'b0, prechCycles};
    end
  end

  gap_counter u_act_gap (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .load      (actLoad),
    .loadValue (actGap),
    .done      (actDone)
  );

  // Precharge gap after an SDRAM write in row-strobe-hold mode.
  gap_counter u_pre_gap (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .load      (writeDone && sdramSel && holdModeOn),
    .loadValue ({1'b0, wpdCycles}),
    .done      (preDone)
  );

  // An activate may follow straight on from the end of the refresh precharge.
  assign activateOk  = actDone && (state_q == ST_IDLE || state_q == ST_REFRESH_END);
  assign prechargeOk = preDone && (state_q != ST_WRITE_REC || !holdModeOn);

endmodule : dram_sdram_timing_control
`default_nettype wire

// ==== dv/mem_seq_model.sv ====
// Purpose: Stand-in for the bus sequencer that reports memory events.
// Assumes: The bench asks for one event at a time.
// Notes: Each event is a single-cycle pulse, as the block expects.
`timescale 1ns/1ps
`default_nettype none
module mem_seq_model (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Request from the bench.
  input  wire logic       fire,
  input  wire logic [1:0] evt,
  // Event pulses toward the block.
  output logic            activateReq,
  output logic            writeDone,
  output logic            prechargeReq,
  output logic            refreshDone
);
  // Quiet until asked, so no memory traffic precedes register setup.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      activateReq  <= 1'b0;
      writeDone    <= 1'b0;
      prechargeReq <= 1'b0;
      refreshDone  <= 1'b0;
    end else begin
      activateReq  <= fire && evt == 2'h0;
      writeDone    <= fire && evt == 2'h1;
      prechargeReq <= fire && evt == 2'h2;
      refreshDone  <= fire && evt == 2'h3;
    end
  end
endmodule : mem_seq_model
`default_nettype wire

// ==== dv/timing_ctrl_checker.sv ====
// Purpose: Port-level checks for the DRAM timing control block.
// Assumes: Write address and data are taken at the same edge.
// Notes: A shadow of the control register follows bus writes.
`timescale 1ns/1ps
`default_nettype none
module timing_ctrl_checker
  import dram_timing_pkg::*;
(
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register bus.
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Memory side.
  input wire logic        sdramSel,
  input wire logic        autoPrecharge,
  input wire logic        writeDone,
  input wire logic        refreshDone,
  input wire logic        activateOk,
  input wire logic        prechargeOk,
  input wire logic        holdModeOn,
  input wire logic        initModeRegSet,
  input wire logic        refreshOn,
  input wire logic [3:0]  casNegCycles,
  input wire logic [3:0]  rcdCycles
);
  logic [31:0] ctrlQ;   // Shadow of the control register.
  logic [3:0]  rdAddrQ; // Address of the read in flight.
  logic [3:0]  rcdExp;  // Expected row-to-column delay.
  // Mirror writes lane by lane; reserved bits never stick.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlQ <= 32'h00000000;
    end else if (s_axi_wvalid && s_axi_wready && s_axi_awaddr == TIMING_CTRL_ADDR) begin
      for (int i = 0; i < 4; i++) begin
        if (s_axi_wstrb[i]) ctrlQ[8*i +: 8] <= s_axi_wdata[8*i +: 8] & TIMING_CTRL_WMASK[8*i +: 8];
      end
    end
  end
  // Remember which word a read asked for.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rdAddrQ <= 4'h0;
    else if (s_axi_arvalid && s_axi_arready) rdAddrQ <= s_axi_araddr;
  end
  // Code zero is prohibited on synchronous parts; the design clamps it to two.
  always_comb begin
    if (sdramSel) rcdExp = (ctrlQ[17:16] == 2'h0) ? 4'h2 : {2'h0, ctrlQ[17:16]} + 4'h1;
    else rcdExp = {2'h0, ctrlQ[17:16]} + 4'h2;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reset_values_a: assert property ($rose(rst_n) |-> !holdModeOn && !initModeRegSet && !refreshOn)
    else $error("outputs not cleared by reset");
  ctrl_readback_a: assert property (s_axi_rvalid && rdAddrQ == TIMING_CTRL_ADDR |-> s_axi_rdata == ctrlQ)
    else $error("control readback differs");
  hold_bit_a: assert property (s_axi_bvalid |-> holdModeOn == ctrlQ[HOLD_BIT])
    else $error("hold mode level wrong");
  init_cmd_a: assert property (s_axi_bvalid |-> initModeRegSet == ctrlQ[INITCMD_BIT])
    else $error("init command level wrong");
  refresh_bit_a: assert property (s_axi_bvalid |-> refreshOn == ctrlQ[REFRESH_BIT])
    else $error("refresh enable level wrong");
  cas_negate_a: assert property (s_axi_bvalid |-> casNegCycles == (ctrlQ[CASNEG_BIT] ? 4'h2 : 4'h1))
    else $error("column negate count wrong");
  rcd_decode_a: assert property (s_axi_bvalid |-> rcdCycles == rcdExp)
    else $error("row to column delay wrong");
  refresh_gap_a: assert property (refreshDone && ctrlQ[29:27] != 3'h0 |=> !activateOk)
    else $error("activate allowed after refresh");
  write_gap_a: assert property (writeDone && sdramSel && autoPrecharge && !holdModeOn |=> !activateOk[*2])
    else $error("activate allowed after write");
  hold_write_a: assert property (writeDone && sdramSel && holdModeOn |=> !prechargeOk)
    else $error("precharge allowed after write");
endmodule : timing_ctrl_checker
bind dram_sdram_timing_control timing_ctrl_checker u_timing_ctrl_checker (
  .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .sdramSel(sdramSel), .autoPrecharge(autoPrecharge),
  .writeDone(writeDone), .refreshDone(refreshDone), .activateOk(activateOk), .prechargeOk(prechargeOk),
  .holdModeOn(holdModeOn), .initModeRegSet(initModeRegSet), .refreshOn(refreshOn),
  .casNegCycles(casNegCycles), .rcdCycles(rcdCycles));
`default_nettype wire

// ==== dv/dram_sdram_timing_control_tb.sv ====
// Purpose: Self-checking bench for the DRAM timing control block.
// Assumes: Bus transfers run one at a time.
// Notes: Gaps are counted as low cycles of a permit over a fixed window.
`timescale 1ns/1ps
`default_nettype none
module dram_sdram_timing_control_tb;
  import dram_timing_pkg::*;
  // Bench-driven inputs, all defined at time zero.
  logic mclk = 1'b0, rst_n = 1'b0, fire = 1'b0, sdramSel = 1'b0, autoPrecharge = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [1:0] evt = 2'h0;
  // Design outputs.
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic activateReq, writeDone, prechargeReq, refreshDone, activateOk, prechargeOk;
  logic holdModeOn, initModeRegSet, refreshOn;
  logic [3:0] casNegCycles, rcdCycles;
  // Bookkeeping.
  int failures = 0, samplesChecked = 0, cycles = 0;
  logic [31:0] d, q;
  logic [1:0] r;
  // 250 MHz clock.
  always #2 mclk = ~mclk;
  dram_sdram_timing_control u_dram_sdram_timing_control (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .sdramSel(sdramSel), .autoPrecharge(autoPrecharge),
    .activateReq(activateReq), .writeDone(writeDone), .prechargeReq(prechargeReq), .refreshDone(refreshDone),
    .activateOk(activateOk), .prechargeOk(prechargeOk), .holdModeOn(holdModeOn),
    .initModeRegSet(initModeRegSet), .refreshOn(refreshOn), .casNegCycles(casNegCycles), .rcdCycles(rcdCycles));
  mem_seq_model u_mem_seq_model (.mclk(mclk), .rst_n(rst_n), .fire(fire), .evt(evt), .activateReq(activateReq),
    .writeDone(writeDone), .prechargeReq(prechargeReq), .refreshDone(refreshDone));
  // Verdict in one place.
  task automatic complete_run();
    if (failures == 0 && samplesChecked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Hang guard, far above the expected run length.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  // Compare and count.
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samplesChecked++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  // Expected row-to-column delay; code zero is clamped on synchronous parts.
  function automatic logic [31:0] rcd_exp(input logic sd, input logic [1:0] c);
    if (sd) return (c == 2'h0) ? 32'h2 : 32'(c) + 32'h1;
    return 32'(c) + 32'h2;
  endfunction : rcd_exp
  // Write with address and data offered together; an idle edge follows so strobes never clash.
  task automatic wr(input logic [3:0] a, input logic [31:0] dat, input logic [3:0] s, output logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask : wr
  // Read one word.
  task automatic rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : rd
  // One-cycle event request toward the sequencer model.
  task automatic pulse(input logic [1:0] e);
    evt <= e;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
  endtask : pulse
  // Fire one event and count blocked cycles; the event cycle itself is blocked as well.
  task automatic gap(input logic [1:0] e, input logic pre, input logic [31:0] n);
    int cnt;
    cnt = 0;
    pulse(e);
    repeat (40) begin
      @(posedge mclk);
      if ((pre ? prechargeOk : activateOk) === 1'b0) cnt++;
    end
    chk(32'(cnt), n);
  endtask : gap
  initial begin
    d = $urandom(32'hC24781AD);
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(TIMING_CTRL_ADDR, q, r);
    chk(q, TIMING_CTRL_RESET);
    // Random words, reserved bits included on purpose.
    repeat (8) begin
      d = $urandom;
      sdramSel <= d[5];
      wr(TIMING_CTRL_ADDR, d, 4'hF, r);
      rd(TIMING_CTRL_ADDR, q, r);
      chk(q, d & TIMING_CTRL_WMASK);
      chk(holdModeOn, d[31]);
      chk(initModeRegSet, d[30]);
      chk(refreshOn, d[2]);
      chk(casNegCycles, d[23] ? 32'h2 : 32'h1);
      chk(rcdCycles, rcd_exp(d[5], d[17:16]));
    end
    // One lane only, then a refused write and an unmapped read.
    wr(TIMING_CTRL_ADDR, 32'hFFFFFFFF, 4'h1, r);
    rd(TIMING_CTRL_ADDR, q, r);
    chk(q, (d | 32'h000000FF) & TIMING_CTRL_WMASK);
    wr(TIMING_STAT_ADDR, 32'h0, 4'hF, r);
    chk(r, RESP_SLVERR);
    rd(4'hC, q, r);
    chk(r, RESP_SLVERR);
    chk(q, 32'h0);
    sdramSel <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(TIMING_CTRL_ADDR, 32'(c) << RFEND_LSB, 4'hF, r);
      gap(2'h3, 1'b0, 32'(3 * c + 1));
    end
    for (int p = 0; p < 16; p++) begin
      sdramSel <= p[3];
      wr(TIMING_CTRL_ADDR, 32'(p % 8) << PRECH_LSB, 4'hF, r);
      // Open a row first; the request cycle and the precharge cycle also hold activate off.
      pulse(2'h0);
      @(posedge mclk);
      gap(2'h2, 1'b0, 32'(p % 8 + p / 8 + 2));
    end
    sdramSel <= 1'b1;
    autoPrecharge <= 1'b1;
    for (int w = 0; w < 5; w++) begin
      d = $urandom_range(7);
      wr(TIMING_CTRL_ADDR, (d << PRECH_LSB) | (32'(w) << WPD_LSB), 4'hF, r);
      gap(2'h1, 1'b0, d + 32'(w) + 32'h3);
    end
    for (int w = 0; w < 2; w++) begin
      wr(TIMING_CTRL_ADDR, 32'h80000200 | (32'h1 << PRECH_LSB) | (32'(w) << WPD_LSB), 4'hF, r);
      gap(2'h1, 1'b1, 32'(w + 2));
    end
    // Turning refresh on rewrites every other field with its present value.
    rd(TIMING_CTRL_ADDR, q, r);
    wr(TIMING_CTRL_ADDR, q | 32'h00000004, 4'hF, r);
    chk(refreshOn, 32'h1);
    chk(holdModeOn, q[HOLD_BIT]);
    // Second reset in mid-run.
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(TIMING_CTRL_ADDR, q, r);
    chk(q, TIMING_CTRL_RESET);
    complete_run();
  end
endmodule : dram_sdram_timing_control_tb
`default_nettype wire
